// *** rtl/sccr_lockwin.sv ***
// lock window and lock count decode
`timescale 1ns/1ps
`include "sccr_regs.svh"
module sccr_lockwin (
  input  wire logic [1:0]        lock_precision,
  input  wire logic              lock_mode,
  input  wire logic [1:0]        lock_count,
  output sccr_pkg::sccr_window_t lock_window,
  output logic [4:0]             lock_cycles_sel
);
  assign lock_window = lock_mode ? sccr_pkg::SCCR_WIN_2P9
                                 : sccr_pkg::sccr_window_t'({1'b0, lock_precision});
  // count index passed to analog detector
  assign lock_cycles_sel = {3'h0, lock_count};
endmodule

// *** rtl/sccr_pkg.sv ***
// types shared by the synthesizer control register bank
package sccr_pkg;
  typedef enum logic [2:0] {
    SCCR_WIN_5P0,
    SCCR_WIN_6P0,
    SCCR_WIN_8P0,
    SCCR_WIN_12P0,
    SCCR_WIN_2P9
  } sccr_window_t;
  typedef enum logic {SCCR_REF_SINGLE, SCCR_REF_DIFF} sccr_refmode_t;
endpackage

// *** rtl/sccr_regs.svh ***
// bit positions, control codes and fixed word of the synthesizer control registers
`ifndef SCCR_REGS_SVH
`define SCCR_REGS_SVH
`define SCCR_SEL_REF      4'h4
`define SCCR_SEL_FIXED    4'h5
`define SCCR_SEL_OUT      4'h6
`define SCCR_SEL_LOCK     4'h7
`define SCCR_SEL_FREQ     4'h0
`define SCCR_FIXED_WORD   32'h00800005
`define SCCR_B_REFDIFF    9
`define SCCR_B_MUXLVL     8
`define SCCR_B_DETPOL     7
`define SCCR_B_PDN        6
`define SCCR_B_CPTRI      5
`define SCCR_B_CNTRST     4
`define SCCR_B_DBUF       14
`define SCCR_B_GBLEED     30
`define SCCR_B_NBLEED     29
`define SCCR_B_FBSEL      24
`define SCCR_F_DIV_HI     23
`define SCCR_F_DIV_LO     21
`define SCCR_F_BLEED_HI   20
`define SCCR_F_BLEED_LO   13
`define SCCR_B_MUTE       11
`define SCCR_B_AUXEN      9
`define SCCR_F_AUXPWR_HI  8
`define SCCR_F_AUXPWR_LO  7
`define SCCR_B_RFEN       6
`define SCCR_F_RFPWR_HI   5
`define SCCR_F_RFPWR_LO   4
`define SCCR_B_LESYNC     25
`define SCCR_F_LDC_HI     9
`define SCCR_F_LDC_LO     8
`define SCCR_B_LOL        7
`define SCCR_F_LDP_HI     6
`define SCCR_F_LDP_LO     5
`define SCCR_B_LDM        4
`define SCCR_WORD_BITS    32
`endif

// *** rtl/sccr_shifter.sv ***
// serial shift register capturing 32-bit words, msb first
`timescale 1ns/1ps
`include "sccr_regs.svh"
module sccr_shifter (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        load_enable,
  output logic [31:0]      word,
  output logic             word_valid
);
  logic        clk_q;
  logic        le_q;
  logic [31:0] shift;
  wire         clk_rise = ser_clk & ~clk_q;
  wire         le_rise  = load_enable & ~le_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      clk_q      <= 1'b0;
      le_q       <= 1'b0;
      shift      <= 32'h0;
      word       <= 32'h0;
      word_valid <= 1'b0;
    end else begin
      clk_q      <= ser_clk;
      le_q       <= load_enable;
      word_valid <= le_rise;
      if (clk_rise)
        shift <= {shift[30:0], ser_data};
      if (le_rise)
        word <= shift;
    end
  end

  AST_LE_VALID: assert property (@(posedge mclk) disable iff (srst)
    le_rise |=> word_valid && word == $past(shift))
    else $error("word not transferred on load edge");
endmodule

// *** rtl/sccr_top.sv ***
// control register bank of the fractional-N synthesizer
`timescale 1ns/1ps
`include "sccr_regs.svh"
module sccr_top (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic              load_enable,
  input  wire logic              ref_rise,
  input  wire logic              digital_lock,
  output sccr_pkg::sccr_refmode_t ref_mode,
  output logic                   mux_level_select,
  output logic                   detector_polarity,
  output logic                   soft_power_down,
  output logic                   pump_tristate,
  output logic                   counters_load_state,
  output logic                   counter_reset_bit,
  output logic                   lock_detect_reset,
  output logic                   vco_enable,
  output logic                   counter_hold,
  output logic                   double_buffer_en,
  output logic                   bleed_on,
  output logic                   negative_bleed_en,
  output logic [7:0]             bleed_level,
  output logic                   feedback_select,
  output logic [2:0]             output_divider_select,
  output logic                   rf_main_on,
  output logic [1:0]             rf_main_power,
  output logic                   rf_aux_on,
  output logic [1:0]             rf_aux_power,
  output logic                   loss_of_lock_mode,
  output sccr_pkg::sccr_window_t lock_window,
  output logic [4:0]             lock_cycles_sel,
  output logic                   divider_load,
  output logic [31:0]            fixed_word_seen
);
  logic [31:0] word;
  logic        word_valid;
  logic [31:0] reference_counter_control;
  logic [31:0] fixed_reserved_word;
  logic [31:0] output_feedback_bleed;
  logic [31:0] lock_detect_config;
  logic [2:0]  div_active;
  logic        load_pending;

  function automatic logic sel_is(input logic [31:0] w, input logic [3:0] code);
    sel_is = (w[3:0] == code);
  endfunction

  sccr_shifter u_shift (
    .mclk        (mclk),
    .srst        (srst),
    .ser_clk     (ser_clk),
    .ser_data    (ser_data),
    .load_enable (load_enable),
    .word        (word),
    .word_valid  (word_valid)
  );

  wire wr_ref   = word_valid & sel_is(word, `SCCR_SEL_REF);
  wire wr_fixed = word_valid & sel_is(word, `SCCR_SEL_FIXED);
  wire wr_out   = word_valid & sel_is(word, `SCCR_SEL_OUT);
  wire wr_lock  = word_valid & sel_is(word, `SCCR_SEL_LOCK);
  wire wr_freq  = word_valid & sel_is(word, `SCCR_SEL_FREQ);

  // power-up reset only; power-down leaves contents alone
  // registers retained in power-down
  always_ff @(posedge mclk) begin
    if (srst) begin
      reference_counter_control <= 32'h0;
      fixed_reserved_word       <= 32'h0;
      output_feedback_bleed     <= 32'h0;
      lock_detect_config        <= 32'h0;
    end else begin
      if (wr_ref)
        reference_counter_control <= word;
      if (wr_fixed)
        fixed_reserved_word <= word;
      if (wr_out)
        output_feedback_bleed <= word;
      if (wr_lock)
        lock_detect_config <= word;
    end
  end

  // fixed word stored for observation only
  assign fixed_word_seen = fixed_reserved_word;

  assign ref_mode = sccr_pkg::sccr_refmode_t'(reference_counter_control[`SCCR_B_REFDIFF]);
  assign mux_level_select  = reference_counter_control[`SCCR_B_MUXLVL];
  assign detector_polarity = reference_counter_control[`SCCR_B_DETPOL];
  assign soft_power_down   = reference_counter_control[`SCCR_B_PDN];
  assign counter_reset_bit = reference_counter_control[`SCCR_B_CNTRST];
  assign double_buffer_en  = reference_counter_control[`SCCR_B_DBUF];

  // pump tristate, also forced in power-down
  assign pump_tristate       = reference_counter_control[`SCCR_B_CPTRI] | soft_power_down;
  assign counters_load_state = soft_power_down;
  assign lock_detect_reset   = soft_power_down;
  assign vco_enable          = ~soft_power_down;
  assign counter_hold        = counter_reset_bit;

  wire lock_ok = digital_lock & ~lock_detect_reset;

  assign bleed_on = ~soft_power_down &
                    (~output_feedback_bleed[`SCCR_B_GBLEED] | lock_ok);
  assign negative_bleed_en = output_feedback_bleed[`SCCR_B_NBLEED];
  assign bleed_level = output_feedback_bleed[`SCCR_F_BLEED_HI:`SCCR_F_BLEED_LO];
  assign feedback_select = output_feedback_bleed[`SCCR_B_FBSEL];

  // mute until lock, stages off in power-down
  wire out_allow = ~soft_power_down & (~output_feedback_bleed[`SCCR_B_MUTE] | lock_ok);
  assign rf_main_on    = out_allow & output_feedback_bleed[`SCCR_B_RFEN];
  assign rf_aux_on     = out_allow & output_feedback_bleed[`SCCR_B_AUXEN];
  assign rf_main_power = output_feedback_bleed[`SCCR_F_RFPWR_HI:`SCCR_F_RFPWR_LO];
  assign rf_aux_power  = output_feedback_bleed[`SCCR_F_AUXPWR_HI:`SCCR_F_AUXPWR_LO];

  // divider select buffered by register 0 write
  wire [2:0] div_written = output_feedback_bleed[`SCCR_F_DIV_HI:`SCCR_F_DIV_LO];
  wire       div_update  = ~double_buffer_en | wr_freq;
  always_ff @(posedge mclk) begin
    if (srst)
      div_active <= 3'h0;
    else if (div_update)
      div_active <= div_written;
  end
  assign output_divider_select = double_buffer_en ? div_active : div_written;

  assign loss_of_lock_mode = lock_detect_config[`SCCR_B_LOL];

  sccr_lockwin u_lockwin (
    .lock_precision  (lock_detect_config[`SCCR_F_LDP_HI:`SCCR_F_LDP_LO]),
    .lock_mode       (lock_detect_config[`SCCR_B_LDM]),
    .lock_count      (lock_detect_config[`SCCR_F_LDC_HI:`SCCR_F_LDC_LO]),
    .lock_window     (lock_window),
    .lock_cycles_sel (lock_cycles_sel)
  );

  // divider load, optionally aligned to reference rise
  wire le_sync = lock_detect_config[`SCCR_B_LESYNC];
  always_ff @(posedge mclk) begin
    if (srst) begin
      load_pending <= 1'b0;
      divider_load <= 1'b0;
    end else begin
      divider_load <= 1'b0;
      if (le_sync) begin
        if (load_pending & ref_rise) begin
          divider_load <= 1'b1;
          load_pending <= wr_freq;
        end else if (wr_freq)
          load_pending <= 1'b1;
      end else begin
        divider_load <= wr_freq;
        load_pending <= 1'b0;
      end
    end
  end

  AST_PDN_EFFECTS: assert property (@(posedge mclk) disable iff (srst)
    soft_power_down |-> pump_tristate && !vco_enable && !rf_main_on && !rf_aux_on)
    else $error("power-down effects missing");
  AST_PDN_COUNTERS: assert property (@(posedge mclk) disable iff (srst)
    soft_power_down |-> counters_load_state && lock_detect_reset)
    else $error("counters or lock detect not reset in power-down");
  AST_PDN_RETAIN: assert property (@(posedge mclk) disable iff (srst)
    soft_power_down && !wr_out |=> output_feedback_bleed == $past(output_feedback_bleed))
    else $error("register changed without write");
  AST_REF_STABLE: assert property (@(posedge mclk) disable iff (srst)
    !wr_ref |=> reference_counter_control == $past(reference_counter_control))
    else $error("reference register changed without write");
  AST_LOAD_IN_PDN: assert property (@(posedge mclk) disable iff (srst)
    soft_power_down && wr_lock |=> lock_detect_config == $past(word))
    else $error("write lost in power-down");
  AST_OUT_IN_PDN: assert property (@(posedge mclk) disable iff (srst)
    soft_power_down && wr_out |=> output_feedback_bleed == $past(word))
    else $error("output write lost in power-down");
  AST_ROUTE_OUT: assert property (@(posedge mclk) disable iff (srst)
    word_valid && word[3:0] == `SCCR_SEL_OUT |=> output_feedback_bleed == $past(word))
    else $error("output register not routed");
  AST_ROUTE_LOCK: assert property (@(posedge mclk) disable iff (srst)
    word_valid && word[3:0] == `SCCR_SEL_LOCK |=> lock_detect_config == $past(word))
    else $error("lock register not routed");
  AST_UNKNOWN_CODE: assert property (@(posedge mclk) disable iff (srst)
    word_valid && !wr_ref && !wr_out && !wr_lock |=>
      output_feedback_bleed == $past(output_feedback_bleed) &&
      lock_detect_config == $past(lock_detect_config))
    else $error("register written by foreign code");
  AST_ROUTE_REF: assert property (@(posedge mclk) disable iff (srst)
    word_valid && word[3:0] == `SCCR_SEL_REF |=> reference_counter_control == $past(word))
    else $error("reference register not routed");
  AST_FIXED: assert property (@(posedge mclk) disable iff (srst)
    wr_fixed |=> fixed_word_seen == $past(word))
    else $error("fixed word not stored");
  AST_REF_MODE: assert property (@(posedge mclk) disable iff (srst)
    (ref_mode == sccr_pkg::SCCR_REF_DIFF) == reference_counter_control[`SCCR_B_REFDIFF])
    else $error("reference mode wrong");
  AST_MUX_LEVEL: assert property (@(posedge mclk) disable iff (srst)
    mux_level_select == reference_counter_control[`SCCR_B_MUXLVL])
    else $error("mux level wrong");
  AST_DETPOL: assert property (@(posedge mclk) disable iff (srst)
    detector_polarity == reference_counter_control[`SCCR_B_DETPOL])
    else $error("detector polarity wrong");
  AST_TRISTATE: assert property (@(posedge mclk) disable iff (srst)
    reference_counter_control[`SCCR_B_CPTRI] |-> pump_tristate)
    else $error("pump not tristated");
  AST_CNT_HOLD: assert property (@(posedge mclk) disable iff (srst)
    counter_hold == reference_counter_control[`SCCR_B_CNTRST])
    else $error("counter hold wrong");
  AST_DBUF_EN: assert property (@(posedge mclk) disable iff (srst)
    double_buffer_en == reference_counter_control[`SCCR_B_DBUF])
    else $error("double buffer enable wrong");
  AST_GATED_BLEED: assert property (@(posedge mclk) disable iff (srst)
    output_feedback_bleed[`SCCR_B_GBLEED] && !digital_lock |-> !bleed_on)
    else $error("bleed on before lock");
  AST_NBLEED: assert property (@(posedge mclk) disable iff (srst)
    negative_bleed_en == output_feedback_bleed[`SCCR_B_NBLEED])
    else $error("negative bleed wrong");
  AST_FBSEL: assert property (@(posedge mclk) disable iff (srst)
    feedback_select == output_feedback_bleed[`SCCR_B_FBSEL])
    else $error("feedback select wrong");
  AST_BLEED_LEVEL: assert property (@(posedge mclk) disable iff (srst)
    bleed_level == output_feedback_bleed[`SCCR_F_BLEED_HI:`SCCR_F_BLEED_LO])
    else $error("bleed level wrong");
  AST_MUTE: assert property (@(posedge mclk) disable iff (srst)
    output_feedback_bleed[`SCCR_B_MUTE] && !digital_lock |-> !rf_main_on && !rf_aux_on)
    else $error("output on before lock");
  AST_RF_EN: assert property (@(posedge mclk) disable iff (srst)
    (rf_main_on |-> output_feedback_bleed[`SCCR_B_RFEN]) and
    (rf_aux_on |-> output_feedback_bleed[`SCCR_B_AUXEN]))
    else $error("output on while disabled");
  AST_RF_PWR: assert property (@(posedge mclk) disable iff (srst)
    rf_main_power == output_feedback_bleed[`SCCR_F_RFPWR_HI:`SCCR_F_RFPWR_LO] &&
    rf_aux_power == output_feedback_bleed[`SCCR_F_AUXPWR_HI:`SCCR_F_AUXPWR_LO])
    else $error("output power wrong");
  AST_DBUF_HOLD: assert property (@(posedge mclk) disable iff (srst)
    double_buffer_en && !wr_freq ##1 double_buffer_en |->
      output_divider_select == $past(output_divider_select))
    else $error("divider changed without register 0 write");
  AST_DBUF_LOAD: assert property (@(posedge mclk) disable iff (srst)
    double_buffer_en && wr_freq ##1 double_buffer_en |->
      output_divider_select == $past(div_written))
    else $error("divider not taken on register 0 write");
  AST_DIRECT_DIV: assert property (@(posedge mclk) disable iff (srst)
    !double_buffer_en |-> output_divider_select == div_written)
    else $error("divider not immediate");
  AST_LDM_WIN: assert property (@(posedge mclk) disable iff (srst)
    lock_detect_config[`SCCR_B_LDM] |-> lock_window == sccr_pkg::SCCR_WIN_2P9)
    else $error("lock mode window wrong");
  AST_LDC: assert property (@(posedge mclk) disable iff (srst)
    lock_cycles_sel[1:0] == lock_detect_config[`SCCR_F_LDC_HI:`SCCR_F_LDC_LO])
    else $error("lock count wrong");
  AST_LOL: assert property (@(posedge mclk) disable iff (srst)
    loss_of_lock_mode == lock_detect_config[`SCCR_B_LOL])
    else $error("loss-of-lock mode wrong");
  AST_SYNC_LOAD: assert property (@(posedge mclk) disable iff (srst)
    le_sync && divider_load |-> $past(ref_rise))
    else $error("divider load not aligned to reference");
  AST_DIRECT_LOAD: assert property (@(posedge mclk) disable iff (srst)
    !le_sync && wr_freq |=> divider_load)
    else $error("divider load missing");

  // main scenarios
  COV_PDN: cover property (@(posedge mclk) disable iff (srst) $rose(soft_power_down));
  COV_DBUF: cover property (@(posedge mclk) disable iff (srst) double_buffer_en && wr_freq);
  COV_SYNC: cover property (@(posedge mclk) disable iff (srst) le_sync && divider_load);
  COV_MUTE_LOCK: cover property (@(posedge mclk) disable iff (srst)
    output_feedback_bleed[`SCCR_B_MUTE] && rf_main_on);
  COV_UNKNOWN: cover property (@(posedge mclk) disable iff (srst)
    word_valid && !wr_ref && !wr_fixed && !wr_out && !wr_lock && !wr_freq);
endmodule

// *** verif/sccr_host_model.sv ***
// host model shifting words into the control register bank
`timescale 1ns/1ps
module sccr_host_model (
  input  wire logic mclk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_enable
);
  // serial clock parks low between frames
  initial begin
    ser_clk     = 1'h0;
    ser_data    = 1'h0;
    load_enable = 1'h0;
  end
  // h sets mclk edges per serial phase, so slow hosts get exercised too
  task automatic send(input logic [31:0] w, input int h);
    for (int i = 31; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (h) @(posedge mclk);
      ser_clk <= 1'h1;
      repeat (h) @(posedge mclk);
      ser_clk <= 1'h0;
    end
    // released data line must not keep showing the last bit
    ser_data <= ~w[0];
    repeat (h) @(posedge mclk);
    load_enable <= 1'h1;
    repeat (2) @(posedge mclk);
    load_enable <= 1'h0;
  endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the synthesizer control register bank
`timescale 1ns/1ps
module tb_top;
  logic                    mclk, srst, ser_clk, ser_data, load_enable, ref_rise, digital_lock;
  sccr_pkg::sccr_refmode_t ref_mode;
  sccr_pkg::sccr_window_t  lock_window;
  logic                    mux_level_select, detector_polarity, soft_power_down, pump_tristate;
  logic                    counters_load_state, counter_reset_bit, lock_detect_reset, vco_enable;
  logic                    counter_hold, double_buffer_en, bleed_on, negative_bleed_en;
  logic                    feedback_select, rf_main_on, rf_aux_on, loss_of_lock_mode, divider_load;
  logic [7:0]              bleed_level;
  logic [2:0]              output_divider_select, dq;
  logic [1:0]              rf_main_power, rf_aux_power;
  logic [4:0]              lock_cycles_sel;
  logic [31:0]             fixed_word_seen, r4, r6, r7, f5;
  int                      error_cnt, checks_done, nld, n0;

  sccr_top i_dut (.mclk, .srst, .ser_clk, .ser_data, .load_enable, .ref_rise, .digital_lock,
    .ref_mode, .mux_level_select, .detector_polarity, .soft_power_down, .pump_tristate,
    .counters_load_state, .counter_reset_bit, .lock_detect_reset, .vco_enable, .counter_hold,
    .double_buffer_en, .bleed_on, .negative_bleed_en, .bleed_level, .feedback_select,
    .output_divider_select, .rf_main_on, .rf_main_power, .rf_aux_on, .rf_aux_power,
    .loss_of_lock_mode, .lock_window, .lock_cycles_sel, .divider_load, .fixed_word_seen);
  sccr_host_model i_host (.mclk, .ser_clk, .ser_data, .load_enable);

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (srst)
      nld <= 0;
    else if (divider_load === 1'h1)
      nld <= nld + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] legal(input logic [31:0] w, input logic [3:0] c);
    legal = {w[31:4], c};
    // polarity fixed at 1; random words keep double buffering off
    if (c == 4'h4) begin
      legal[7]  = 1'h1;
      legal[14] = 1'h0;
    end
    if (c == 4'h6) begin
      legal[31]    = 1'h0;
      legal[28:25] = 4'ha;
      legal[12]    = 1'h0;
      legal[10]    = 1'h0;
    end
    // reserved lock bits, load sync left off
    if (c == 4'h7)
      legal = {3'h0, 1'h1, 2'h0, 1'h0, 15'h0, w[9:4], c};
    if (c == 4'h5)
      legal = 32'h00800005;
  endfunction

  task automatic check_all();
    logic pd;
    logic mu;
    pd = r4[6];
    mu = !pd && (!r6[11] || digital_lock);
    chk("ref_mode", ref_mode, r4[9]);
    chk("mux_level", mux_level_select, r4[8]);
    chk("polarity", detector_polarity, r4[7]);
    chk("power_down", soft_power_down, pd);
    chk("pump_tri", pump_tristate, r4[5] | pd);
    chk("pd_effects", {counters_load_state, lock_detect_reset, vco_enable}, {pd, pd, !pd});
    chk("cnt_reset", {counter_reset_bit, counter_hold}, {2{r4[4]}});
    chk("dbuf", double_buffer_en, r4[14]);
    chk("fixed", fixed_word_seen, f5);
    chk("bleed_on", bleed_on, !pd && (!r6[30] || digital_lock));
    chk("bleed", {negative_bleed_en, bleed_level}, {r6[29], r6[20:13]});
    chk("fb_sel", feedback_select, r6[24]);
    chk("div_sel", output_divider_select, r4[14] ? dq : r6[23:21]);
    chk("rf_on", {rf_main_on, rf_aux_on}, {mu && r6[6], mu && r6[9]});
    chk("rf_pwr", {rf_main_power, rf_aux_power}, {r6[5:4], r6[8:7]});
    chk("lol", loss_of_lock_mode, r7[7]);
    chk("window", lock_window, r7[4] ? 3'h4 : {1'h0, r7[6:5]});
    chk("lock_cnt", lock_cycles_sel, r7[9:8]);
  endtask

  task automatic wr(input logic [31:0] w);
    i_host.send(w, 1 + int'($urandom % 3));
    case (w[3:0])
      4'h0: dq = r6[23:21];
      4'h4: r4 = w;
      4'h5: f5 = w;
      4'h6: r6 = w;
      4'h7: r7 = w;
      default: ;
    endcase
    repeat (3) @(posedge mclk);
    check_all();
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    final_report();
  end

  initial begin
    srst = 1'h1;
    ref_rise = 1'h0;
    digital_lock = 1'h0;
    {r4, r6, r7, f5, dq} = '0;
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(94));
    repeat (5) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    check_all();
    $display("test reset done");
    for (int n = 0; n < 32; n++) begin
      digital_lock <= 1'($urandom);
      wr(legal($urandom, 4'h4 + 4'(n % 4)));
    end
    $display("test random done");
    // codes 8 to 15, outside this bank, must leave every register alone
    for (int c = 8; c < 16; c++)
      wr({28'($urandom), 4'(c)});
    $display("test unknown codes done");
    wr(r4 | 32'h40);
    wr(legal($urandom, 4'h6));
    wr(legal($urandom, 4'h7));
    wr(r4 & ~32'h40);
    $display("test power down done");
    n0 = nld;
    wr({28'($urandom), 4'h0});
    chk("load_cnt", nld, n0 + 1);
    wr(r4 | 32'h4000);
    wr({r6[31:24], ~dq, r6[20:0]});
    wr({28'($urandom), 4'h0});
    wr(r4 & ~32'h4000);
    $display("test double buffer done");
    wr(r7 | 32'h02000000);
    n0 = nld;
    wr({28'($urandom), 4'h0});
    chk("sync_hold", nld, n0);
    ref_rise <= 1'h1;
    @(posedge mclk);
    ref_rise <= 1'h0;
    for (int k = 0; k < 8 && nld == n0; k++)
      @(posedge mclk);
    chk("sync_load", nld, n0 + 1);
    $display("test load sync done");
    final_report();
  end
endmodule
